// >>> hw/odd_pkg.sv
package odd_pkg;
  localparam int DATA_W = 32;
  localparam int RF_AW = 4;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_KERNEL_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_PRIV_BIT = 0;
  localparam int ST_ILL_BIT = 1;
  localparam int ST_CLASS_LSB = 4;
  localparam int ST_EXT_LSB = 8;
  localparam int ST_BASE_LSB = 12;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [7:0] OPC_ESCAPE = 8'h30;
  localparam logic [2:0] MAX_OPERANDS = 3'h4;
  localparam logic [3:0] MODE_REG = 4'h4;
  localparam logic [3:0] MODE_REG_DEF = 4'h5;
  localparam logic [3:0] MODE_FRAME_SO = 4'h6;
  localparam logic [3:0] MODE_ARG_SO = 4'h7;
  localparam logic [3:0] MODE_WDISP = 4'h8;
  localparam logic [3:0] MODE_WDISP_DEF = 4'h9;
  localparam logic [3:0] MODE_HDISP = 4'ha;
  localparam logic [3:0] MODE_HDISP_DEF = 4'hb;
  localparam logic [3:0] MODE_BDISP = 4'hc;
  localparam logic [3:0] MODE_BDISP_DEF = 4'hd;
  localparam logic [3:0] MODE_EXPAND = 4'he;
  localparam logic [3:0] MODE_NEG_LIT = 4'hf;
  localparam logic [3:0] REG_FRAME = 4'h9;
  localparam logic [3:0] REG_ARG = 4'ha;
  localparam logic [3:0] REG_PSW = 4'hb;
  localparam logic [3:0] REG_PCBP = 4'hd;
  localparam logic [3:0] REG_ISP = 4'he;
  localparam logic [3:0] REG_PC = 4'hf;

  typedef enum logic [3:0] {
    CL_POS_LIT, CL_NEG_LIT, CL_REG, CL_REG_DEF, CL_SHORT_OFF, CL_DISP,
    CL_DISP_DEF, CL_IMM, CL_ABS, CL_ABS_DEF, CL_EXPAND
  } odd_class_t;

  typedef enum {ST_OPC, ST_OPC2, ST_DESC, ST_EXT, ST_EMIT} odd_state_t;

  function automatic logic [2:0] odd_ext_len(input logic [3:0] m,
                                             input logic [3:0] r);
    case (m)
      MODE_REG: return (r == REG_PC) ? 3'h4 : 3'h0;
      MODE_REG_DEF: return (r == REG_PC) ? 3'h2 : 3'h0;
      MODE_FRAME_SO: return (r == REG_PC) ? 3'h1 : 3'h0;
      MODE_ARG_SO: return (r == REG_PC) ? 3'h4 : 3'h0;
      MODE_WDISP, MODE_WDISP_DEF: return 3'h4;
      MODE_HDISP, MODE_HDISP_DEF: return 3'h2;
      MODE_BDISP, MODE_BDISP_DEF: return 3'h1;
      MODE_EXPAND: return (r == REG_PC) ? 3'h4 : 3'h0;
      default: return 3'h0;
    endcase
  endfunction : odd_ext_len

  function automatic odd_class_t odd_class(input logic [3:0] m,
                                           input logic [3:0] r);
    case (m)
      MODE_REG: return (r == REG_PC) ? CL_IMM : CL_REG;
      MODE_REG_DEF: return (r == REG_PC) ? CL_IMM : CL_REG_DEF;
      MODE_FRAME_SO: return (r == REG_PC) ? CL_IMM : CL_SHORT_OFF;
      MODE_ARG_SO: return (r == REG_PC) ? CL_ABS : CL_SHORT_OFF;
      MODE_WDISP, MODE_HDISP, MODE_BDISP: return CL_DISP;
      MODE_WDISP_DEF, MODE_HDISP_DEF, MODE_BDISP_DEF: return CL_DISP_DEF;
      MODE_EXPAND: return (r == REG_PC) ? CL_ABS_DEF : CL_EXPAND;
      MODE_NEG_LIT: return CL_NEG_LIT;
      default: return CL_POS_LIT;
    endcase
  endfunction : odd_class
endpackage : odd_pkg

// >>> hw/odd_rf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface odd_rf_if;
  logic [odd_pkg::RF_AW-1:0] raddr;
  logic [odd_pkg::DATA_W-1:0] rdata;
  logic wr_go;
  logic [odd_pkg::RF_AW-1:0] waddr;
  logic [odd_pkg::DATA_W-1:0] wdata;
  modport ctrl (output raddr, wr_go, waddr, wdata, input rdata);
  modport mem (input raddr, wr_go, waddr, wdata, output rdata);
endinterface : odd_rf_if
`default_nettype wire

// >>> hw/odd_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module odd_regfile #(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  odd_rf_if.mem rf
);
  import odd_pkg::*;

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rdata_reg;

  always_ff @(posedge pclk) begin
    if (rf.wr_go) begin
      mem_q[rf.waddr] <= rf.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem_q[rf.raddr];
    end
  end

  assign rf.rdata = rdata_reg;
endmodule : odd_regfile
`default_nettype wire

// >>> hw/operand_descriptor_decoder.sv
// Overview of operation
// - Low nibble register, high nibble mode.
// - Modes 0-3 give unsigned six-bit literal.
// - Mode 4 register; register 15 word immediate.
// - Mode 5 register deferred; 15 halfword immediate.
// - Mode 6 frame pointer offset; 15 byte immediate.
// - Mode 7 argument pointer offset; 15 absolute.
// - Modes 8, A, C register plus displacement.
// - Modes 9, B, D displacement deferred.
// - Mode E expanded type; 15 absolute deferred.
// - Mode F negative literal, -1 to -16.
// - Expanded type adds one byte, keeps lengths.
// - Opcode of one or two bytes, four operands.
// - Privileged register writes outside kernel trap.
// - Program counter used implicitly by control flow.
// - Short offsets only 0 to 14.
// - Registers 0-2 serve as implied arguments.
// - Byte and halfword displacements are sign-extended.
// - Multi-byte data assembled low byte first.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module operand_descriptor_decoder #(
  parameter int ADDR_W = 8,
  parameter int RF_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic [2:0] in_operands,
  output logic in_ready,
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic [31:0] wr_data,
  output logic dec_valid,
  output odd_pkg::odd_class_t dec_class,
  output logic [3:0] dec_base,
  output logic [2:0] dec_ext,
  output logic [31:0] dec_value,
  output logic [31:0] dec_addr,
  output logic dec_deferred,
  output logic dec_expanded,
  output logic [3:0] dec_type,
  output logic dec_illegal,
  output logic priv_exc,
  output logic [31:0] program_counter
);
  import odd_pkg::*;

  function automatic logic is_priv(input logic [3:0] r);
    return (r == REG_PSW) || (r == REG_PCBP) || (r == REG_ISP);
  endfunction : is_priv

  function automatic logic [31:0] sext(input logic [31:0] d,
                                       input logic [2:0] n);
    case (n)
      3'h1: return {{24{d[7]}}, d[7:0]};
      3'h2: return {{16{d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction : sext

  odd_rf_if rf ();

  odd_regfile #(.DEPTH(RF_DEPTH)) u_regfile (
    .pclk(pclk),
    .presetn(presetn),
    .rf(rf)
  );

  odd_state_t state_reg, state_next;
  logic [1:0] ctrl_reg;
  logic priv_sticky_reg, ill_sticky_reg;
  logic [31:0] count_reg, pc_reg, pc_desc_reg;
  logic [2:0] opnd_left_reg, ext_need_reg, ext_got_reg;
  logic [3:0] mode_reg, rsel_reg, base_sel_reg, type_reg;
  odd_class_t cls_reg;
  logic expanded_reg;
  logic [31:0] ext_data_reg;
  logic [7:0] first_ext_reg;
  logic [RF_AW-1:0] raddr_reg;
  logic in_ready_reg, dec_valid_reg, dec_deferred_reg, dec_expanded_reg;
  logic dec_illegal_reg, priv_exc_reg;
  odd_class_t dec_class_reg;
  logic [3:0] dec_base_reg, dec_type_reg;
  logic [2:0] dec_ext_reg;
  logic [31:0] dec_value_reg, dec_addr_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  logic in_fire, expand_now, priv_block, pc_load;
  logic [3:0] in_mode, in_rsel, base_now;
  logic [2:0] need_now;
  logic [31:0] base_val, disp_sx, val_c, ea_c;

  assign in_mode = in_byte[7:4];
  assign in_rsel = in_byte[3:0];
  assign in_fire = in_valid && in_ready_reg;
  assign need_now = odd_ext_len(in_mode, in_rsel);
  assign expand_now = (in_mode == MODE_EXPAND) && (in_rsel != REG_PC)
                      && !expanded_reg;
  assign base_now = (in_mode == MODE_FRAME_SO) ? REG_FRAME :
                    (in_mode == MODE_ARG_SO) ? REG_ARG : in_rsel;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OPC: begin
        if (in_fire) begin
          if (in_byte == OPC_ESCAPE) begin
            state_next = ST_OPC2;
          end else if (in_operands != 3'h0) begin
            state_next = ST_DESC;
          end
        end
      end
      ST_OPC2: begin
        if (in_fire) begin
          state_next = (opnd_left_reg == 3'h0) ? ST_OPC : ST_DESC;
        end
      end
      ST_DESC: begin
        if (in_fire && !expand_now) begin
          state_next = (need_now == 3'h0) ? ST_EMIT : ST_EXT;
        end
      end
      ST_EXT: begin
        if (in_fire && ext_got_reg == ext_need_reg - 3'h1) begin
          state_next = ST_EMIT;
        end
      end
      ST_EMIT: state_next = (opnd_left_reg == 3'h1) ? ST_OPC : ST_DESC;
      default: state_next = ST_OPC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_OPC;
      in_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      in_ready_reg <= ctrl_reg[CTRL_EN_BIT] && (state_next != ST_EMIT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_left_reg <= 3'h0;
    end else if (state_reg == ST_OPC && in_fire) begin
      opnd_left_reg <= (in_operands > MAX_OPERANDS) ? MAX_OPERANDS
                                                    : in_operands;
    end else if (state_reg == ST_EMIT) begin
      opnd_left_reg <= opnd_left_reg - 3'h1;
    end
  end

  // Descriptor capture; the base register read starts here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 4'h0;
      rsel_reg <= 4'h0;
      base_sel_reg <= 4'h0;
      cls_reg <= CL_POS_LIT;
      ext_need_reg <= 3'h0;
      expanded_reg <= 1'b0;
      type_reg <= 4'h0;
      raddr_reg <= '0;
      pc_desc_reg <= PC_RESET;
    end else if (state_reg == ST_DESC && in_fire) begin
      if (expand_now) begin
        expanded_reg <= 1'b1;
        type_reg <= in_rsel;
      end else begin
        mode_reg <= in_mode;
        rsel_reg <= in_rsel;
        cls_reg <= odd_class(in_mode, in_rsel);
        ext_need_reg <= need_now;
        pc_desc_reg <= pc_reg;
        base_sel_reg <= base_now;
        raddr_reg <= base_now;
      end
    end else if (state_reg == ST_EMIT) begin
      expanded_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_got_reg <= 3'h0;
      ext_data_reg <= 32'h0;
      first_ext_reg <= 8'h0;
    end else if (state_reg == ST_DESC) begin
      ext_got_reg <= 3'h0;
      ext_data_reg <= 32'h0;
    end else if (state_reg == ST_EXT && in_fire) begin
      ext_got_reg <= ext_got_reg + 3'h1;
      ext_data_reg <= ext_data_reg | ({24'h0, in_byte} << {ext_got_reg, 3'h0});
      if (ext_got_reg == 3'h0) begin
        first_ext_reg <= in_byte;
      end
    end
  end

  assign base_val = (base_sel_reg == REG_PC) ? pc_desc_reg : rf.rdata;
  assign disp_sx = sext(ext_data_reg, ext_need_reg);

  always_comb begin
    val_c = 32'h0;
    ea_c = 32'h0;
    case (cls_reg)
      CL_POS_LIT: val_c = {26'h0, mode_reg[1:0], rsel_reg};
      CL_NEG_LIT: val_c = {24'hffffff, mode_reg, rsel_reg};
      CL_REG: val_c = base_val;
      CL_REG_DEF: ea_c = base_val;
      CL_SHORT_OFF: ea_c = base_val + {28'h0, rsel_reg};
      CL_DISP, CL_DISP_DEF: begin
        val_c = disp_sx;
        ea_c = base_val + disp_sx;
      end
      CL_IMM: val_c = disp_sx;
      CL_ABS, CL_ABS_DEF: begin
        val_c = ext_data_reg;
        ea_c = ext_data_reg;
      end
      default: val_c = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid_reg <= 1'b0;
      dec_class_reg <= CL_POS_LIT;
      dec_base_reg <= 4'h0;
      dec_ext_reg <= 3'h0;
      dec_value_reg <= 32'h0;
      dec_addr_reg <= 32'h0;
      dec_deferred_reg <= 1'b0;
      dec_expanded_reg <= 1'b0;
      dec_type_reg <= 4'h0;
      dec_illegal_reg <= 1'b0;
    end else begin
      dec_valid_reg <= (state_reg == ST_EMIT);
      if (state_reg == ST_EMIT) begin
        dec_class_reg <= cls_reg;
        dec_base_reg <= base_sel_reg;
        dec_ext_reg <= ext_need_reg;
        dec_value_reg <= val_c;
        dec_addr_reg <= ea_c;
        dec_deferred_reg <= (cls_reg == CL_DISP_DEF) ||
                            (cls_reg == CL_ABS_DEF);
        dec_expanded_reg <= expanded_reg;
        dec_type_reg <= type_reg;
        dec_illegal_reg <= (rsel_reg == REG_PSW) &&
                           (cls_reg == CL_REG_DEF || cls_reg == CL_DISP ||
                            cls_reg == CL_DISP_DEF);
      end
    end
  end

  assign priv_block = wr_en && is_priv(wr_sel) && !ctrl_reg[CTRL_KERNEL_BIT];
  assign pc_load = wr_en && (wr_sel == REG_PC);
  assign rf.wr_go = wr_en && !priv_block && !pc_load;
  assign rf.waddr = wr_sel;
  assign rf.wdata = wr_data;
  // The base read is issued while the descriptor is offered, so the
  // register contents are ready by the report cycle.
  assign rf.raddr = (state_reg == ST_DESC) ? base_now : raddr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= PC_RESET;
    end else if (pc_load) begin
      pc_reg <= wr_data;
    end else if (in_fire) begin
      pc_reg <= pc_reg + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priv_exc_reg <= 1'b0;
    end else begin
      priv_exc_reg <= priv_block;
    end
  end

  logic apb_setup, apb_wr, apb_hit;
  logic [31:0] status_c, rd_c;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign apb_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_COUNT) || (paddr == ADDR_PC);

  always_comb begin
    status_c = 32'h0;
    status_c[ST_PRIV_BIT] = priv_sticky_reg;
    status_c[ST_ILL_BIT] = ill_sticky_reg;
    status_c[ST_CLASS_LSB +: 4] = dec_class_reg;
    status_c[ST_EXT_LSB +: 3] = dec_ext_reg;
    status_c[ST_BASE_LSB +: 4] = dec_base_reg;
    case (paddr)
      ADDR_CTRL: rd_c = {30'h0, ctrl_reg};
      ADDR_STATUS: rd_c = status_c;
      ADDR_COUNT: rd_c = count_reg;
      ADDR_PC: rd_c = pc_reg;
      default: rd_c = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !apb_hit;
      prdata_reg <= (apb_setup && !pwrite) ? rd_c : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // Sticky flags: a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priv_sticky_reg <= 1'b0;
      ill_sticky_reg <= 1'b0;
    end else begin
      if (priv_block) begin
        priv_sticky_reg <= 1'b1;
      end else if (apb_wr && paddr == ADDR_STATUS && pwdata[ST_PRIV_BIT]) begin
        priv_sticky_reg <= 1'b0;
      end
      if (dec_valid_reg && dec_illegal_reg) begin
        ill_sticky_reg <= 1'b1;
      end else if (apb_wr && paddr == ADDR_STATUS && pwdata[ST_ILL_BIT]) begin
        ill_sticky_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h0;
    end else if (state_reg == ST_EMIT) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign in_ready = in_ready_reg;
  assign dec_valid = dec_valid_reg;
  assign dec_class = dec_class_reg;
  assign dec_base = dec_base_reg;
  assign dec_ext = dec_ext_reg;
  assign dec_value = dec_value_reg;
  assign dec_addr = dec_addr_reg;
  assign dec_deferred = dec_deferred_reg;
  assign dec_expanded = dec_expanded_reg;
  assign dec_type = dec_type_reg;
  assign dec_illegal = dec_illegal_reg;
  assign priv_exc = priv_exc_reg;
  assign program_counter = pc_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_priv_block;
    wr_en && is_priv(wr_sel) && !ctrl_reg[CTRL_KERNEL_BIT]
      |-> !rf.wr_go ##1 priv_exc && priv_sticky_reg;
  endproperty
  a_priv_block: assert property (p_priv_block)
    else $error("privileged write not blocked");

  property p_pos_lit;
    dec_valid && dec_class == CL_POS_LIT
      |-> dec_value[31:6] == 26'h0 && dec_ext == 3'h0;
  endproperty
  a_pos_lit: assert property (p_pos_lit)
    else $error("positive literal malformed");

  property p_neg_lit;
    dec_valid && dec_class == CL_NEG_LIT
      |-> dec_value[31:4] == 28'hfffffff && dec_ext == 3'h0;
  endproperty
  a_neg_lit: assert property (p_neg_lit)
    else $error("negative literal out of range");

  property p_short_off;
    dec_valid && dec_class == CL_SHORT_OFF
      |-> (dec_base == REG_FRAME || dec_base == REG_ARG) && dec_ext == 3'h0;
  endproperty
  a_short_off: assert property (p_short_off)
    else $error("short offset base or length wrong");

  property p_abs;
    dec_valid && dec_class == CL_ABS
      |-> dec_ext == 3'h4 && dec_addr == dec_value;
  endproperty
  a_abs: assert property (p_abs)
    else $error("absolute operand wrong");

  property p_sext;
    dec_valid && dec_class == CL_DISP && dec_ext == 3'h1
      |-> dec_value[31:8] == {24{dec_value[7]}};
  endproperty
  a_sext: assert property (p_sext)
    else $error("byte displacement not sign-extended");

  property p_low_first;
    dec_valid && dec_ext != 3'h0 && dec_class != CL_NEG_LIT
      |-> dec_value[7:0] == first_ext_reg;
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("first extension byte not lowest");

  property p_emit_pulse;
    state_reg == ST_EMIT |-> !in_ready ##1 dec_valid ##1 !dec_valid;
  endproperty
  a_emit_pulse: assert property (p_emit_pulse)
    else $error("report pulse timing wrong");

  property p_pc_step;
    in_fire && !pc_load |=> program_counter == $past(program_counter) + 32'h1;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter did not advance");
endmodule : operand_descriptor_decoder
`default_nettype wire

// >>> bench/odd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module odd_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_byte,
  output logic [2:0] in_operands
);
  logic [10:0] q[$];
  task automatic push(input logic [10:0] v);
    q.push_back(v);
  endtask : push
  // An offered byte holds until taken; idle data toggles every cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid <= 1'b0;
      in_byte <= 8'h00;
      in_operands <= 3'h0;
    end else if (!(in_valid && !in_ready)) begin
      if (in_valid) void'(q.pop_front());
      if (q.size() > 0 && $urandom_range(3) != 0) begin
        in_valid <= 1'b1;
        {in_operands, in_byte} <= q[0];
      end else begin
        in_valid <= 1'b0;
        in_byte <= ~in_byte;
      end
    end
  end
endmodule : odd_fetch_model
`default_nettype wire

// >>> bench/operand_descriptor_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module operand_descriptor_decoder_bench;
  import odd_pkg::*;
  typedef struct {
    logic [3:0] c, b, t;
    logic [2:0] x;
    logic [31:0] v, a;
    bit cv, xp;
  } odd_exp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wr_en = 1'b0;
  logic [3:0] wr_sel = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] prdata, dec_value, dec_addr, program_counter, pc, rd;
  logic pready, pslverr, in_valid, in_ready, dec_valid, dec_deferred, er;
  logic dec_expanded, dec_illegal, priv_exc;
  logic [7:0] in_byte;
  logic [2:0] in_operands, dec_ext;
  logic [3:0] dec_base, dec_type;
  odd_class_t dec_class;
  int err_count = 0;
  int checked = 0;
  logic [31:0] regs[16];
  odd_exp_t eq[$];
  odd_exp_t e, last;

  always #12.5 pclk = ~pclk;

  odd_fetch_model fetch (.pclk(pclk), .presetn(presetn),
    .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte),
    .in_operands(in_operands));
  operand_descriptor_decoder dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_byte(in_byte), .in_operands(in_operands),
    .in_ready(in_ready), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .dec_valid(dec_valid), .dec_class(dec_class), .dec_base(dec_base),
    .dec_ext(dec_ext), .dec_value(dec_value), .dec_addr(dec_addr),
    .dec_deferred(dec_deferred), .dec_expanded(dec_expanded),
    .dec_type(dec_type), .dec_illegal(dec_illegal), .priv_exc(priv_exc),
    .program_counter(program_counter));

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checked %0d mismatched %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge pclk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge pclk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic put(input logic [7:0] b, input logic [2:0] n);
    fetch.push({n, b});
    pc = pc + 1;
  endtask : put

  task automatic operand(input logic [3:0] m, input logic [3:0] r,
                         input bit xp, input logic [2:0] n);
    odd_exp_t x;
    logic [31:0] d, s, pcd;
    int len;
    x = '{default: '0};
    x.t = 4'($urandom_range(14));
    x.xp = xp;
    x.b = m == MODE_FRAME_SO ? REG_FRAME : m == MODE_ARG_SO ? REG_ARG : r;
    x.cv = 1'b1;
    len = 0;
    if (xp) put({MODE_EXPAND, x.t}, n);
    pcd = pc;
    put({m, r}, n);
    if (m < 4'h4) x.v = {26'h0, m[1:0], r};
    else if (m == MODE_NEG_LIT) begin
      x.c = CL_NEG_LIT;
      x.v = {28'hfffffff, r};
    end else if (r == REG_PC && m < 4'h8) begin
      len = m == MODE_FRAME_SO ? 1 : m == MODE_REG_DEF ? 2 : 4;
      x.c = m == MODE_ARG_SO ? CL_ABS : CL_IMM;
    end else if (m == MODE_EXPAND) begin
      len = 4;
      x.c = CL_ABS_DEF;
    end else if (m == MODE_REG) x.c = CL_REG;
    else if (m == MODE_REG_DEF) x.c = CL_REG_DEF;
    else if (m < 4'h8) x.c = CL_SHORT_OFF;
    else begin
      len = m < 4'ha ? 4 : m < 4'hc ? 2 : 1;
      x.c = m[0] ? CL_DISP_DEF : CL_DISP;
    end
    x.x = 3'(len);
    d = $urandom;
    for (int i = 0; i < len; i++) put(d[8*i +: 8], n);
    s = len == 1 ? {{24{d[7]}}, d[7:0]} :
        len == 2 ? {{16{d[15]}}, d[15:0]} : len == 4 ? d : 32'h0;
    case (x.c)
      CL_REG: x.v = regs[r];
      CL_REG_DEF: begin x.a = regs[r]; x.cv = 1'b0; end
      CL_SHORT_OFF: begin x.a = regs[x.b] + r; x.cv = 1'b0; end
      CL_IMM: x.v = s;
      CL_ABS, CL_ABS_DEF: begin x.v = d; x.a = d; end
      CL_DISP, CL_DISP_DEF: begin
        x.v = s;
        x.a = (r == REG_PC ? pcd : regs[r]) + s;
      end
      default: ;
    endcase
    eq.push_back(x);
  endtask : operand

  always @(posedge pclk) begin
    if (presetn && dec_valid === 1'b1) begin
      e = '{default: 'x};
      if (eq.size() > 0) e = eq.pop_front();
      last = e;
      check("class", dec_class, e.c);
      check("base", dec_base, e.b);
      check("ext", dec_ext, e.x);
      if (e.cv) check("value", dec_value, e.v);
      check("addr", dec_addr, e.a);
      check("deferred", dec_deferred,
            e.c == CL_DISP_DEF || e.c == CL_ABS_DEF);
      check("expanded", dec_expanded, e.xp);
      if (e.xp) check("type", dec_type, e.t);
      check("illegal", dec_illegal, 1'b0);
    end
  end

  initial begin
    #500000;
    err_count++;
    report_and_stop();
  end

  initial begin
    int n, k, ops;
    logic [3:0] m, r;
    void'($urandom(46519));
    pc = 32'h0;
    k = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl_reset", rd, {30'h0, CTRL_RESET});
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_err", er, 1'b1);
    $display("test apb done");
    apb(1'b1, ADDR_CTRL, 32'h3);
    for (int i = 0; i < 15; i++) begin
      regs[i] = $urandom;
      wr(i[3:0], regs[i]);
    end
    pc = $urandom;
    wr(REG_PC, pc);
    @(posedge pclk);
    check("pc_load", program_counter, pc);
    apb(1'b1, ADDR_CTRL, 32'h1);
    wr(REG_PSW, ~regs[REG_PSW]);
    @(posedge pclk);
    check("priv_exc", priv_exc, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("priv_sticky", rd[ST_PRIV_BIT], 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h3);
    $display("test registers done");
    put(8'h10, 3'h1);
    operand(MODE_REG, REG_PSW, 1'b0, 3'h1);
    for (int i = 0; i < 24; i++) begin
      ops = $urandom_range(4);
      if (i % 3 == 0) put(OPC_ESCAPE, 3'(ops));
      put(8'h40 + i[7:0], 3'(ops));
      for (int j = 0; j < ops; j++) begin
        m = k[3:0];
        r = k[5:4] == 2'h0 ? REG_PC : 4'($urandom);
        if (r == REG_PSW && (m == MODE_REG_DEF || m[3:2] == 2'h2 ||
            m == MODE_BDISP || m == MODE_BDISP_DEF)) r = 4'h3;
        if (m == MODE_EXPAND) r = REG_PC;
        operand(m, r, k[5] && m != MODE_EXPAND, 3'(ops));
        k++;
      end
    end
    n = 0;
    while (eq.size() > 0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    check("drained", eq.size(), 0);
    check("pc_count", program_counter, pc);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd & 32'hf7f3,
          {16'h0, last.b, 1'b0, last.x, last.c, 4'h0});
    apb(1'b0, ADDR_COUNT, 32'h0);
    check("count", rd, 32'(k + 1));
    apb(1'b0, ADDR_PC, 32'h0);
    check("pc_reg", rd, pc);
    $display("test stream done");
    report_and_stop();
  end
endmodule : operand_descriptor_decoder_bench
`default_nettype wire
